// file: verilog/adcp_top.sv
// Conversion sequencer and result readout port of an 18-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "adcp_regs.svh"
// How it works
// - Unfinished external serial read: discard, pulse flag
// - Pins 14 to 17 always outputs
// - Busy high from start until result latched
// - Pins 0-13 driven only with select and read low; pin 13 always in external serial
// - Chip select gates external serial clock
// - Reset input aborts conversion, clears logic
// - Power down: finish, then refuse starts
// - Start falling edge holds and converts
// - Impulse mode: start low at acquisition end converts
// - Mode pins pick 18, 16, 8-bit or serial
// - 18-bit mode: result bit n on pin n
// - 16-bit mode: word select picks high/low word
// - 8-bit mode: pins 3-9 off, byte selected
// - Low byte placement follows byte select
// - Result coding follows format select
// - Serial data leaves MSB first
module adcp_top
  import adcp_pkg::*;
#(
  parameter int RW = `ADCP_RESULT_WIDTH,
  parameter int CONV_CYCLES = `ADCP_CONV_CYCLES,
  parameter int ACQ_CYCLES = `ADCP_ACQ_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reset_request,
  // Conversion control
  input wire logic conversion_start_n,
  input wire logic power_down_request,
  input wire logic impulse_sel,
  input wire logic fast_sel,
  input wire logic [RW-1:0] core_code,
  output logic sample_hold,
  output logic busy,
  output logic low_power_state,
  // Port configuration
  input wire logic port_mode_select_hi,
  input wire logic port_mode_select_lo,
  input wire logic output_format_select,
  input wire logic word_select,
  input wire logic byte_select,
  input wire logic serial_clock_source_select,
  // Read strobes and serial clock input
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk_in,
  // Data pins
  output logic [RW-1:0] data_pin_out,
  output logic [RW-1:0] data_pin_oe,
  output logic incomplete_read_flag
);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] ACQ_LAST = 16'(ACQ_CYCLES - 1);

  adcp_conv_state_t state_reg;
  adcp_port_mode_t port_mode;
  logic [15:0] cnt_reg;
  logic start_prev_reg;
  logic start_fall;
  logic impulse_mode;
  logic can_start;
  logic conv_go;
  logic conv_done;
  logic logic_rst_n;
  logic [RW-1:0] cap_reg;
  logic cap_pending_reg;
  logic [RW-1:0] out_reg;
  logic out_load;
  logic rd_en;
  logic ext_mode;
  logic ser_sdout;
  logic ser_sclk;
  logic ser_sync;
  logic ser_partial;
  logic err_reg;
  logic [RW-1:0] pin_val;
  logic [RW-1:0] pin_oe;
  logic [2*RW-1:0] par_map;

  adcp_stream_if #(.WIDTH(RW)) cap_if ();
  adcp_stream_if #(.WIDTH(RW)) out_if ();

  // Straight binary core code to the selected output coding
  function automatic logic [RW-1:0] code_format(input logic [RW-1:0] raw,
                                                input logic twos);
    code_format = twos ? {~raw[RW-1], raw[RW-2:0]} : raw;
  endfunction

  // Parallel pin map: {output enables, pin values}
  function automatic logic [2*RW-1:0] par_pins(input adcp_port_mode_t m,
                                               input logic ws,
                                               input logic bs,
                                               input logic [RW-1:0] r);
    logic [RW-1:0] v;
    logic [RW-1:0] e;
    v = '0;
    e = '0;
    case (m)
      ADCP_MODE_PAR18: begin
        v = r;
        e = '1;
      end
      ADCP_MODE_WORD16: begin
        e = {{(RW-2){1'b1}}, 2'b00};
        if (!ws) begin
          v = {r[RW-1:2], 2'b00};
        end else begin
          v = {{(RW-4){1'b0}}, r[1:0], 2'b00};
        end
      end
      ADCP_MODE_BYTE8: begin
        e = {8'hff, 10'h000};
        case ({ws, bs})
          2'b00: v = {r[17:10], 10'h000};
          2'b01: v = {r[9:2], 10'h000};
          2'b10: v = {6'h00, r[1:0], 10'h000};
          default: v = {r[1:0], 16'h0000};
        endcase
      end
      default: begin
        v = '0;
        e = '0;
      end
    endcase
    par_pins = {e, v};
  endfunction

  assign logic_rst_n = rst_n && !reset_request;
  assign port_mode = adcp_port_mode_t'({port_mode_select_hi,
                                        port_mode_select_lo});
  assign ext_mode = serial_clock_source_select;
  assign impulse_mode = impulse_sel && !fast_sel;
  assign start_fall = start_prev_reg && !conversion_start_n;
  // no new start while powered down
  assign can_start = !power_down_request && !cap_pending_reg
                     && cap_if.ready;
  assign conv_done = (state_reg == ADCP_CONV) && (cnt_reg == CONV_LAST);

  always_comb begin
    conv_go = 1'b0;
    case (state_reg)
      ADCP_ACQ: begin
        if (impulse_mode) begin
          conv_go = (cnt_reg == ACQ_LAST) && !conversion_start_n
                    && can_start;
        end else begin
          conv_go = start_fall && can_start;
        end
      end
      ADCP_READY: conv_go = start_fall && can_start;
      default: conv_go = 1'b0;
    endcase
  end

  // Start pin history for edge detection
  always_ff @(posedge ref_clk) begin
    if (!logic_rst_n) begin
      start_prev_reg <= 1'b1;
    end else begin
      start_prev_reg <= conversion_start_n;
    end
  end

  // abort on reset; without reset a running conversion always finishes
  always_ff @(posedge ref_clk) begin
    if (!logic_rst_n) begin
      state_reg <= ADCP_ACQ;
      cnt_reg <= `ADCP_RESET_CNT;
    end else begin
      case (state_reg)
        ADCP_ACQ: begin
          if (conv_go) begin
            state_reg <= ADCP_CONV;
            cnt_reg <= `ADCP_RESET_CNT;
          end else if (cnt_reg == ACQ_LAST) begin
            state_reg <= ADCP_READY;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ADCP_READY: begin
          if (conv_go) begin
            state_reg <= ADCP_CONV;
            cnt_reg <= `ADCP_RESET_CNT;
          end
        end
        ADCP_CONV: begin
          if (conv_done) begin
            state_reg <= ADCP_ACQ;
            cnt_reg <= `ADCP_RESET_CNT;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= ADCP_ACQ;
          cnt_reg <= `ADCP_RESET_CNT;
        end
      endcase
    end
  end

  // capture the coded result at conversion end
  always_ff @(posedge ref_clk) begin
    if (!logic_rst_n) begin
      cap_reg <= '0;
      cap_pending_reg <= 1'b0;
    end else if (conv_done) begin
      cap_reg <= code_format(core_code, output_format_select);
      cap_pending_reg <= 1'b1;
    end else if (cap_if.ready) begin
      cap_pending_reg <= 1'b0;
    end
  end

  assign cap_if.valid = cap_pending_reg;
  assign cap_if.data = cap_reg;

  adcp_skid_buf #(
    .WIDTH(RW),
    .DEPTH(`ADCP_BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_n(logic_rst_n),
    .up(cap_if),
    .dn(out_if)
  );

  assign rd_en = !cs_n && !rd_n;
  // Hold the word steady under a parallel read or an internal-clock shift;
  // an external-clock read is overrun on purpose and flagged
  assign out_if.ready = !((port_mode != ADCP_MODE_SERIAL) && rd_en)
    && !((port_mode == ADCP_MODE_SERIAL) && !ext_mode && ser_partial);
  assign out_load = out_if.valid && out_if.ready;

  // Output register that the parallel pins read from; the shifter loads out_if.data
  always_ff @(posedge ref_clk) begin
    if (!logic_rst_n) begin
      out_reg <= '0;
    end else if (out_load) begin
      out_reg <= out_if.data;
    end
  end

  // busy until the word reaches the output register
  assign busy = (state_reg == ADCP_CONV) || cap_pending_reg || out_if.valid;
  assign sample_hold = (state_reg == ADCP_CONV);
  assign low_power_state = power_down_request && (state_reg != ADCP_CONV);

  adcp_serial_tx #(
    .WIDTH(RW),
    .HALF(`ADCP_SCLK_HALF)
  ) u_ser (
    .ref_clk(ref_clk),
    .rst_n(logic_rst_n),
    .load(out_load && (port_mode == ADCP_MODE_SERIAL)),
    .load_word(out_if.data),
    .ext_clk_sel(ext_mode),
    .sclk_in(sclk_in),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .sdout(ser_sdout),
    .sclk_out(ser_sclk),
    .frame_sync(ser_sync),
    .partial_read(ser_partial)
  );

  // one-cycle flag on overrun of an external read
  always_ff @(posedge ref_clk) begin
    if (!logic_rst_n) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= out_load && (port_mode == ADCP_MODE_SERIAL) && ext_mode
                 && ser_partial;
    end
  end
  assign incomplete_read_flag = err_reg;

  assign par_map = par_pins(port_mode, word_select, byte_select, out_reg);

  always_comb begin
    pin_val = par_map[RW-1:0];
    pin_oe = rd_en ? par_map[2*RW-1:RW] : '0;
    if (port_mode == ADCP_MODE_SERIAL) begin
      pin_val = '0;
      pin_oe = '0;
      pin_val[`ADCP_PIN_SDOUT] = ser_sdout;
      pin_oe[`ADCP_PIN_SDOUT] = rd_en;
      pin_val[`ADCP_PIN_SCLK] = ser_sclk;
      pin_oe[`ADCP_PIN_SCLK] = rd_en && !ext_mode;
      pin_val[`ADCP_PIN_SYNC] = ser_sync;
      pin_oe[`ADCP_PIN_SYNC] = rd_en && !ext_mode;
      pin_val[`ADCP_PIN_ERR] = err_reg;
      pin_oe[`ADCP_PIN_ERR] = ext_mode;
    end
    pin_oe[RW-1:`ADCP_PIN_UPPER_LO] = '1;
  end

  // Pins registered so data leaves from flip-flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_pin_out <= '0;
      data_pin_oe <= {4'hf, 14'h0000};
    end else begin
      data_pin_out <= pin_val;
      data_pin_oe <= pin_oe;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!logic_rst_n);

  sequence s_conv_begin;
    conv_go;
  endsequence
  sequence s_conv_run;
    (busy && sample_hold) [*8];
  endsequence

  a_busy_on_start: assert property (s_conv_begin |=> s_conv_run)
    else $error("busy or hold not high after start");
  a_busy_until_latch: assert property ($fell(busy) |-> $past(out_load))
    else $error("busy fell before the result was latched");
  a_err_cause: assert property (out_load && port_mode == ADCP_MODE_SERIAL
    && ext_mode && ser_partial |=> incomplete_read_flag)
    else $error("overrun not flagged");
  a_err_pulse: assert property (incomplete_read_flag |=>
    !incomplete_read_flag || $past(out_load))
    else $error("read error flag held without new overrun");
  a_upper_out: assert property (&data_pin_oe[RW-1:`ADCP_PIN_UPPER_LO])
    else $error("upper data pins released");
  a_hiz_unread: assert property (!rd_en && port_mode != ADCP_MODE_SERIAL
    |=> data_pin_oe[`ADCP_PIN_UPPER_LO-1:0] == '0)
    else $error("lower pins driven without read");
  a_pd_no_start: assert property (power_down_request
    && state_reg != ADCP_CONV |=> state_reg != ADCP_CONV)
    else $error("conversion started in power down");
  a_conv_finish: assert property (sample_hold && cnt_reg == 16'h0000
    |-> ##(CONV_CYCLES - 1) conv_done ##1 !sample_hold)
    else $error("conversion length wrong");
  a_impulse_go: assert property (state_reg == ADCP_ACQ && impulse_mode
    && cnt_reg == ACQ_LAST && !conversion_start_n && can_start
    |=> sample_hold)
    else $error("impulse start missed");
  a_reset_abort: assert property (@(posedge ref_clk) disable iff (1'b0)
    reset_request |=> !sample_hold && !busy)
    else $error("reset did not abort");
endmodule // adcp_top
`default_nettype wire

// file: verilog/adcp_regs.svh
// Timing counts, widths and pin positions of the converter output port
`ifndef ADCP_REGS_SVH
`define ADCP_REGS_SVH

`define ADCP_CLK_MHZ 200
`define ADCP_RESULT_WIDTH 18
`define ADCP_BUF_DEPTH 2
// Conversion and acquisition phases, in nanoseconds
`define ADCP_CONV_TIME_NS 1000
`define ADCP_ACQ_TIME_NS 250
// Least times, so cycle counts round up
`define ADCP_CONV_CYCLES ((`ADCP_CONV_TIME_NS * `ADCP_CLK_MHZ + 999) / 1000)
`define ADCP_ACQ_CYCLES ((`ADCP_ACQ_TIME_NS * `ADCP_CLK_MHZ + 999) / 1000)
// Internal serial clock: one half period in ref_clk cycles
`define ADCP_SCLK_HALF 2
// Pins reused by the serial port, and the always-output group
`define ADCP_PIN_SDOUT 10
`define ADCP_PIN_SCLK 11
`define ADCP_PIN_SYNC 12
`define ADCP_PIN_ERR 13
`define ADCP_PIN_UPPER_LO 14
`define ADCP_RESET_CNT 16'h0000

`endif

// file: verilog/adcp_pkg.sv
// Types shared by the converter output port modules
`default_nettype none
package adcp_pkg;
  typedef enum logic [1:0] {
    ADCP_MODE_PAR18,
    ADCP_MODE_WORD16,
    ADCP_MODE_BYTE8,
    ADCP_MODE_SERIAL
  } adcp_port_mode_t;

  typedef enum logic [1:0] {
    ADCP_ACQ,
    ADCP_READY,
    ADCP_CONV
  } adcp_conv_state_t;
endpackage
`default_nettype wire

// file: verilog/adcp_stream_if.sv
// Valid/ready word channel between the port modules
`timescale 1ns/1ps
`default_nettype none
interface adcp_stream_if #(parameter int WIDTH = 18);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verilog/adcp_skid_buf.sv
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adcp_skid_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Filling and draining sides
  adcp_stream_if.snk up,
  adcp_stream_if.src dn
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Pointer step with wrap at the depth
  function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p);
    step_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest flags; the stored word drives the data output
  assign up.ready = (count_reg != (AW + 1)'(DEPTH));
  assign dn.valid = (count_reg != '0);
  assign dn.data = mem_reg[rd_ptr_reg];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= up.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= step_ptr(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= step_ptr(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  a_buf_no_overflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    count_reg <= (AW + 1)'(DEPTH))
    else $error("buffer fill level above depth");
  a_buf_hold_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
    else $error("stalled word changed or vanished");
endmodule // adcp_skid_buf
`default_nettype wire

// file: verilog/adcp_serial_tx.sv
// Serial result shifter with external or internal shift clock
`timescale 1ns/1ps
`default_nettype none
`include "adcp_regs.svh"
module adcp_serial_tx #(
  parameter int WIDTH = `ADCP_RESULT_WIDTH,
  parameter int HALF = `ADCP_SCLK_HALF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Word to send
  input wire logic load,
  input wire logic [WIDTH-1:0] load_word,
  // Host side
  input wire logic ext_clk_sel,
  input wire logic sclk_in,
  input wire logic cs_n,
  input wire logic rd_n,
  // Serial outputs and status
  output logic sdout,
  output logic sclk_out,
  output logic frame_sync,
  output logic partial_read
);
  localparam logic [4:0] DONE = 5'(WIDTH);

  logic [WIDTH-1:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic sclk_prev_reg;
  logic sclk_out_reg;
  logic [7:0] div_cnt_reg;
  logic ext_rise;
  logic int_run;
  logic int_tick;
  logic shift_now;

  assign ext_rise = ext_clk_sel && !cs_n && sclk_in && !sclk_prev_reg;
  assign int_run = !ext_clk_sel && !cs_n && !rd_n && (bit_cnt_reg != DONE);
  assign int_tick = int_run && (div_cnt_reg == 8'(HALF - 1));
  // Advance on the falling internal edge so data is stable at the rise
  assign shift_now = (ext_rise || (int_tick && sclk_out_reg))
                     && (bit_cnt_reg != DONE);

  assign sdout = shift_reg[WIDTH-1];
  assign sclk_out = sclk_out_reg;
  assign frame_sync = int_run;
  assign partial_read = (bit_cnt_reg != 5'h00) && (bit_cnt_reg != DONE);

  // Edge history of the external clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_in;
    end
  end

  // Internal clock divider, idles low between reads
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !int_run) begin
      div_cnt_reg <= 8'h00;
      sclk_out_reg <= 1'b0;
    end else if (int_tick) begin
      div_cnt_reg <= 8'h00;
      sclk_out_reg <= !sclk_out_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
      bit_cnt_reg <= DONE;
    end else if (load) begin
      shift_reg <= load_word;
      bit_cnt_reg <= 5'h00;
    end else if (shift_now) begin
      shift_reg <= {shift_reg[WIDTH-2:0], 1'b0};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  a_ser_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load |=> sdout == $past(load_word[WIDTH-1]))
    else $error("first serial bit is not the MSB");
  a_ser_cs_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_n && !load |=> $stable(bit_cnt_reg))
    else $error("shifted while chip select inactive");
endmodule // adcp_serial_tx
`default_nettype wire

// file: bench/adcp_host_model.sv
// Host-side reader model: strobes, serial clock and pin sampling
`timescale 1ns/1ps
`default_nettype none
module adcp_host_model (
  // Clock
  input wire logic ref_clk,
  // Strobes and serial clock to the port
  output logic cs_n,
  output logic rd_n,
  output logic sclk_in,
  // Pins from the port
  input wire logic [17:0] data_pin_out,
  input wire logic [17:0] data_pin_oe
);
  logic [17:0] seen;

  // Undriven pins read as the inverse, so a stale value never matches
  assign seen = (data_pin_out & data_pin_oe) | (~data_pin_out & ~data_pin_oe);

  // Idle host: deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk_in = 1'b0;
  end

  task automatic par_read(output logic [17:0] w, output logic [17:0] oe);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    w = seen;
    oe = data_pin_oe;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask

  // Slow external clock; bit taken before each rise
  task automatic ser_read(input int n, input logic sel_n,
                          output logic [17:0] bits);
    bits = 18'h00000;
    @(posedge ref_clk);
    cs_n <= sel_n;
    rd_n <= sel_n;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      #1;
      bits = {bits[16:0], seen[10]};
      @(posedge ref_clk);
      sclk_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask

  // Internal clock; bit taken at each rise of pin 11
  task automatic int_read(output logic [17:0] bits, output int rises);
    logic prev;
    bits = 18'h00000;
    rises = 0;
    prev = 1'b0;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (int i = 0; i < 120; i++) begin
      @(posedge ref_clk);
      #1;
      if (seen[11] && !prev) begin
        bits = {bits[16:0], seen[10]};
        rises++;
      end
      prev = seen[11];
    end
    @(posedge ref_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
endmodule // adcp_host_model
`default_nettype wire

// file: bench/adcp_top_tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
    end \
  end
module adcp_top_tb;
  import adcp_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, reset_request = 1'b0;
  logic conversion_start_n = 1'b1, power_down_request = 1'b0;
  logic impulse_sel = 1'b0, fast_sel = 1'b0;
  logic port_mode_select_hi = 1'b0, port_mode_select_lo = 1'b0;
  logic output_format_select = 1'b0, word_select = 1'b0, byte_select = 1'b0;
  logic serial_clock_source_select = 1'b1;
  logic [17:0] core_code = 18'h00000;
  logic cs_n, rd_n, sclk_in, sample_hold, busy, low_power_state, flag, hit;
  logic [17:0] data_pin_out, data_pin_oe, w, oe, bits, c;
  logic [35:0] e;
  logic [3:0] keys [7] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb};
  int compares = 0;
  int n_mismatch = 0;
  int rises;

  // Short counts keep the run brief
  adcp_top #(.CONV_CYCLES(10), .ACQ_CYCLES(4)) adcp_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reset_request(reset_request),
    .conversion_start_n(conversion_start_n),
    .power_down_request(power_down_request), .impulse_sel(impulse_sel),
    .fast_sel(fast_sel), .core_code(core_code), .sample_hold(sample_hold),
    .busy(busy), .low_power_state(low_power_state),
    .port_mode_select_hi(port_mode_select_hi),
    .port_mode_select_lo(port_mode_select_lo),
    .output_format_select(output_format_select), .word_select(word_select),
    .byte_select(byte_select),
    .serial_clock_source_select(serial_clock_source_select),
    .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .incomplete_read_flag(flag));

  adcp_host_model adcp_host_model_inst (
    .ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait on busy; a timeout ends the run
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (busy !== lvl) begin
      n_mismatch++;
      $display("CHECK FAILED busy wait exp %h got %h", lvl, busy);
      close_out();
    end
  endtask

  // Start edge, held three cycles with busy and hold checked, then released
  task automatic convert(input logic [17:0] code);
    @(posedge ref_clk);
    core_code <= code;
    conversion_start_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("busy at start", 1'b1, busy);
    `CHK("hold at start", 1'b1, sample_hold);
    @(posedge ref_clk);
    conversion_start_n <= 1'b1;
  endtask

  // Expected enables in the top half, pin values in the bottom half
  function automatic logic [35:0] expect_pins(input logic [3:0] k,
                                              input logic [17:0] v);
    case (k)
      4'h0: return {18'h3ffff, v};
      4'h4: return {18'h3fffc, v[17:2], 2'h0};
      4'h6: return {18'h3fffc, 14'h0000, v[1:0], 2'h0};
      4'h8: return {18'h3fc00, v[17:10], 10'h000};
      4'h9: return {18'h3fc00, v[9:2], 10'h000};
      4'ha: return {18'h3fc00, 6'h00, v[1:0], 10'h000};
      default: return {18'h3fc00, v[1:0], 16'h0000};
    endcase
  endfunction

  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("enables in reset", 18'h3c000, data_pin_oe);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // Every parallel layout, one conversion each
    for (int i = 0; i < 7; i++) begin
      c = 18'h2b5c6 ^ 18'(i * 18'h01111);
      {port_mode_select_hi, port_mode_select_lo} <= keys[i][3:2];
      {word_select, byte_select} <= keys[i][1:0];
      convert(c);
      wait_busy(1'b0, 60);
      adcp_host_model_inst.par_read(w, oe);
      e = expect_pins(keys[i], c);
      `CHK("parallel pins", e[17:0], w & e[35:18]);
      `CHK("pin enables", e[35:18], oe);
      `CHK("byte mode gap", 7'h00, oe[9:3] & {7{keys[i][3]}});
    end
    // Two's complement flips the MSB
    {port_mode_select_hi, port_mode_select_lo} <= 2'h0;
    output_format_select <= 1'b1;
    convert(18'h01234);
    wait_busy(1'b0, 60);
    adcp_host_model_inst.par_read(w, oe);
    `CHK("twos complement", 18'h21234, w);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("idle enables", 18'h3c000, data_pin_oe);
    // Serial, external clock; deselected clocks must not shift
    {port_mode_select_hi, port_mode_select_lo} <= 2'h3;
    output_format_select <= 1'b0;
    convert(18'h3a5c3);
    wait_busy(1'b0, 60);
    adcp_host_model_inst.ser_read(3, 1'b1, bits);
    adcp_host_model_inst.ser_read(18, 1'b0, bits);
    `CHK("serial word", 18'h3a5c3, bits);
    // Partial read overtaken by the next result
    convert(18'h15555);
    wait_busy(1'b0, 60);
    adcp_host_model_inst.ser_read(5, 1'b0, bits);
    `CHK("serial top bits", 18'h0000a, bits);
    convert(18'h00001);
    hit = 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      #1;
      if (flag === 1'b1) hit = 1'b1;
    end
    `CHK("incomplete read flag", 1'b1, hit);
    // Serial, internal clock: 18 rises on pin 11, MSB first
    serial_clock_source_select <= 1'b0;
    convert(18'h2c3a5);
    wait_busy(1'b0, 60);
    adcp_host_model_inst.int_read(bits, rises);
    `CHK("internal serial word", 18'h2c3a5, bits);
    `CHK("internal clock rises", 18, rises);
    // Power down lets the running conversion finish, then refuses
    {port_mode_select_hi, port_mode_select_lo} <= 2'h0;
    convert(18'h0f0f0);
    @(posedge ref_clk);
    power_down_request <= 1'b1;
    wait_busy(1'b0, 60);
    adcp_host_model_inst.par_read(w, oe);
    `CHK("word before power down", 18'h0f0f0, w);
    conversion_start_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("start refused", 1'b0, busy);
    `CHK("low power", 1'b1, low_power_state);
    @(posedge ref_clk);
    conversion_start_n <= 1'b1;
    power_down_request <= 1'b0;
    // Reset input aborts a running conversion
    convert(18'h12345);
    @(posedge ref_clk);
    reset_request <= 1'b1;
    impulse_sel <= 1'b1;
    conversion_start_n <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    reset_request <= 1'b0;
    #1;
    `CHK("busy after reset", 1'b0, busy);
    `CHK("hold after reset", 1'b0, sample_hold);
    // Impulse mode: start still low when acquisition ends converts
    wait_busy(1'b1, 20);
    `CHK("impulse start", 1'b1, sample_hold);
    @(posedge ref_clk);
    conversion_start_n <= 1'b1;
    impulse_sel <= 1'b0;
    wait_busy(1'b0, 60);
    close_out();
  end
endmodule // adcp_top_tb
`undef CHK
`default_nettype wire
